// ### hdl/sci_top.sv
// Serial command port: receiver, line FIFO, reply sequencer, transmitter and AHB-Lite slave.
//
// Contract
// - Bit rate comes from an eight-position one-hot selector, 75 to 1200 baud.
// - Only 300 and 1200 are supported; an invalid selection falls back to 300. The code decodes all eight rates.
// - Word selector positions read 0 open, 1 closed; unused positions are ignored.
// - Positions 1-2 pick stop bits: 01 one, 11 two; one is the default.
// - Position 3 picks parity sense, 1 even, 0 odd, for sending and checking.
// - Position 4 enables a parity bit after the data bits.
// - Positions 5-6 pick 5, 6, 7 or 8 data bits; seven is supported.
// - Received characters are held in a 256-character input FIFO.
// - CR LF or a lone LF ends an input line.
// - Every reply ends with CR then LF.
// - Characters accumulate; interpretation starts only after the line end.
// - Setting codes are stored and get no reply.
// - An output request is answered right after the line end arrives.
// - With several requests on a line, only the last one is answered.
// - Local state refreshes parameters from the panel; remote only by host.
// - Terminator and end-status codes are stored but change nothing.
// - Reception errors do not stop operation; characters are still kept.
// - Flag parity, overrun, framing and FIFO overflow; drop characters past 256.
// - A pending error code goes out ahead of the next reply data.
// - Errors clear once the first reply after them has been sent.
// - Idle line is mark; each character starts with one space start bit.
// - Parity bit makes the ones count odd or even as chosen.
// - Transmit only while DSR, CTS and DCD are all asserted.
// - Reception is blocked while DCD is off; DTR is asserted when running.
`timescale 1ns/100ps
`include "sci_cfg.svh"

module sci_top
   import sci_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic rxd_in,
   input wire logic cts_in,
   input wire logic dsr_in,
   input wire logic dcd_in,
   output logic txd_out,
   output logic rts_out,
   output logic dtr_out,
   input wire logic [7:0] baud_select_switch_in,
   input wire logic [5:0] word_format_switch_in,
   input wire logic [15:0] panel_param_in
);

   // ****************************************************************
   // Decoding functions
   // ****************************************************************

   // Sixteenth-bit divisor for the selected rate; a selection that is not one-hot
   // falls back to the default rather than running at an undefined rate.
   function automatic logic [15:0] baud_div(input logic [7:0] sel);
      logic [15:0] d;
      case (sel)
         8'h01: d = 16'(`SCI_CLK_HZ / (`SCI_OVERSAMPLE * `SCI_BAUD_P1));
         8'h02: d = 16'(`SCI_CLK_HZ / (`SCI_OVERSAMPLE * `SCI_BAUD_P2));
         8'h04: d = 16'(`SCI_CLK_HZ / (`SCI_OVERSAMPLE * `SCI_BAUD_P3));
         8'h08: d = 16'(`SCI_CLK_HZ / (`SCI_OVERSAMPLE * `SCI_BAUD_P4));
         8'h10: d = 16'(`SCI_CLK_HZ / (`SCI_OVERSAMPLE * `SCI_BAUD_P5));
         8'h20: d = 16'(`SCI_CLK_HZ / (`SCI_OVERSAMPLE * `SCI_BAUD_P6));
         8'h40: d = 16'(`SCI_CLK_HZ / (`SCI_OVERSAMPLE * `SCI_BAUD_P7));
         8'h80: d = 16'(`SCI_CLK_HZ / (`SCI_OVERSAMPLE * `SCI_BAUD_P8));
         default: d = 16'(`SCI_CLK_HZ / (`SCI_OVERSAMPLE * `SCI_BAUD_DEFAULT));
      endcase
      return d;
   endfunction : baud_div

   // Word format from the six selector positions; index 0 is position 1.
   function automatic sci_fmt_t decode_fmt(input logic [5:0] w);
      sci_fmt_t f;
      f.two_stop = w[0] & w[1];
      f.par_even = w[2];
      f.par_en = w[3];
      f.nbits = 4'h5 + {2'h0, w[4], w[5]};
      return f;
   endfunction : decode_fmt

   // Character of the error prefix "Err1n " at position i.
   function automatic logic [7:0] prefix_char(input logic [2:0] i, input logic [1:0] c);
      logic [7:0] ch;
      case (i)
         3'h0: ch = `SCI_CHAR_E;
         3'h1: ch = `SCI_CHAR_R;
         3'h2: ch = `SCI_CHAR_R;
         3'h3: ch = `SCI_CHAR_ONE;
         3'h4: ch = `SCI_CHAR_ZERO + {6'h00, c};
         default: ch = `SCI_CHAR_SPACE;
      endcase
      return ch;
   endfunction : prefix_char

   // ****************************************************************
   // State and storage
   // ****************************************************************
   sci_state_t s;
   sci_state_t next_s;
   logic [7:0] fifo_mem [0:255];
   sci_fmt_t fmt;
   logic [15:0] div;
   logic rx_line;
   logic flow_ok;
   logic push_ok;
   logic pop;
   logic [7:0] rx_char;
   logic [3:0] err_set;
   logic [3:0] err_clr;
   logic ld;
   logic [7:0] ld_char;
   logic [7:0] mask;
   logic addr_ok;

   // ****************************************************************
   // Next-state logic
   // ****************************************************************

   // All behaviour in one pass over the state record.
   always_comb begin
      next_s = s;
      err_set = 4'h0;
      err_clr = 4'h0;
      rx_char = 8'h00;
      ld = 1'b0;
      ld_char = 8'h00;
      fmt = decode_fmt(s.sync2[17:12]);
      div = baud_div(s.sync2[11:4]);
      mask = 8'(9'h0FF >> (4'h8 - fmt.nbits));
      rx_line = s.sync2[3] | ~s.sync2[0];
      flow_ok = s.sync2[0] & s.sync2[1] & s.sync2[2];
      addr_ok = hsel_in & htrans_in[1] & hready_in;
      pop = addr_ok & ~hwrite_in & (haddr_in[7:0] == `SCI_OFS_RX_DATA) & (s.count != 9'h000);
      push_ok = s.hold_v & (s.count != `SCI_FIFO_DEPTH);
      next_s.rdy = 1'b1;
      next_s.dtr = 1'b1;

      // Pins and switches cross in through two flops before use.
      next_s.sync1 = {panel_param_in, word_format_switch_in, baud_select_switch_in,
                      rxd_in, cts_in, dsr_in, dcd_in};
      next_s.sync2 = s.sync1;

      // Oversampling enable: one pulse per sixteenth of a bit.
      next_s.tick = 1'b0;
      if (s.div_cnt >= div - 16'h0001) begin
         next_s.div_cnt = 16'h0000;
         next_s.tick = 1'b1;
      end else begin
         next_s.div_cnt = s.div_cnt + 16'h0001;
      end

      // Receiver, sampling each bit at mid-cell.
      if (s.tick) begin
         next_s.rx_cnt = s.rx_cnt + 5'h01;
         case (s.rx_st)
            RX_IDLE: begin
               next_s.rx_cnt = 5'h00;
               if (!rx_line) begin
                  next_s.rx_st = RX_START;
               end
            end
            RX_START: begin
               if (s.rx_cnt == `SCI_SAMPLE_MID) begin
                  next_s.rx_cnt = 5'h00;
                  next_s.rx_bits = 4'h0;
                  next_s.rx_par = 1'b0;
                  next_s.rx_st = rx_line ? RX_IDLE : RX_DATA; // Glitch filter on start.
               end
            end
            RX_DATA: begin
               if (s.rx_cnt == `SCI_BIT_LAST) begin
                  next_s.rx_cnt = 5'h00;
                  next_s.rx_sh = {rx_line, s.rx_sh[7:1]};
                  next_s.rx_par = s.rx_par ^ rx_line;
                  next_s.rx_bits = s.rx_bits + 4'h1;
                  next_s.rx_perr = 1'b0;
                  if (s.rx_bits + 4'h1 == fmt.nbits) begin
                     next_s.rx_st = fmt.par_en ? RX_PAR : RX_STOP;
                  end
               end
            end
            RX_PAR: begin
               if (s.rx_cnt == `SCI_BIT_LAST) begin
                  next_s.rx_cnt = 5'h00;
                  next_s.rx_perr = rx_line != (fmt.par_even ? s.rx_par : ~s.rx_par);
                  next_s.rx_st = RX_STOP;
               end
            end
            RX_STOP: begin
               if (s.rx_cnt == `SCI_BIT_LAST) begin
                  // A bad character is still kept so the parser can try it.
                  rx_char = 8'(s.rx_sh >> (4'h8 - fmt.nbits));
                  next_s.hold_d = rx_char;
                  next_s.hold_v = 1'b1;
                  err_set[`SCI_ERR_PARITY] = s.rx_perr;
                  err_set[`SCI_ERR_FRAMING] = ~rx_line;
                  err_set[`SCI_ERR_OVERRUN] = s.hold_v;
                  next_s.rx_st = RX_IDLE;
                  next_s.rx_cnt = 5'h00;
               end
            end
            default: next_s.rx_st = RX_IDLE;
         endcase
      end

      // Hold register drains into the FIFO; overflow drops the character.
      if (s.hold_v) begin
         if (!(s.tick && s.rx_st == RX_STOP && s.rx_cnt == `SCI_BIT_LAST)) begin
            next_s.hold_v = 1'b0;
         end
         err_set[`SCI_ERR_OVERFLOW] = ~push_ok;
         if (s.hold_d == `SCI_CHAR_LF) begin
            next_s.armed = 1'b1;
         end
      end
      next_s.wptr = s.wptr + {7'h00, push_ok};
      next_s.rptr = s.rptr + {7'h00, pop};
      next_s.count = s.count + {8'h00, push_ok} - {8'h00, pop};
      next_s.line_cnt = s.line_cnt
         + {8'h00, push_ok & (s.hold_d == `SCI_CHAR_LF)}
         - {8'h00, pop & (fifo_mem[s.rptr] == `SCI_CHAR_LF)};

      // Parameters follow the panel in local state and only the host in remote.
      if (!s.remote) begin
         next_s.param = s.sync2[33:18];
      end

      // Bus data phase: writes take effect here.
      if (s.a_valid && s.a_write) begin
         case (s.a_addr)
            `SCI_OFS_CTRL: begin
               next_s.remote = hwdata_in[`SCI_CTRL_REMOTE];
               // A reply may only start once a whole line has arrived.
               if (hwdata_in[`SCI_CTRL_REPLY_START] && s.armed && s.seq == SEQ_IDLE) begin
                  next_s.armed = s.hold_v & (s.hold_d == `SCI_CHAR_LF);
                  next_s.snap = s.err;
                  next_s.idx = 3'h0;
                  next_s.end_req = 1'b0;
                  next_s.code = s.err[0] ? 2'h0 : s.err[1] ? 2'h1 : s.err[2] ? 2'h2 : 2'h3;
                  next_s.seq = (s.err != 4'h0) ? SEQ_ERR : SEQ_BODY;
               end
               if (hwdata_in[`SCI_CTRL_REPLY_END] && s.seq != SEQ_IDLE) begin
                  next_s.end_req = 1'b1;
               end
            end
            `SCI_OFS_TX_DATA: begin
               if (s.seq == SEQ_BODY && !s.buf_v && !s.end_req) begin
                  next_s.buf_v = 1'b1;
                  next_s.buf_d = hwdata_in[7:0];
               end
            end
            `SCI_OFS_TERM: next_s.term = hwdata_in[7:0];
            `SCI_OFS_END_STATUS: next_s.endst = hwdata_in[7:0];
            `SCI_OFS_PARAM: begin
               if (s.remote) begin
                  next_s.param = hwdata_in[15:0];
               end
            end
            `SCI_OFS_REQUEST: next_s.request = hwdata_in[7:0];
            default: next_s.request = s.request;
         endcase
      end

      // Bus address phase: capture, and prepare read data for the data phase.
      next_s.a_valid = addr_ok;
      next_s.a_write = hwrite_in;
      next_s.a_addr = haddr_in[7:0];
      if (addr_ok && !hwrite_in) begin
         case (haddr_in[7:0])
            `SCI_OFS_CTRL: next_s.hrdata = {31'h00000000, s.remote};
            `SCI_OFS_STATUS: next_s.hrdata = {4'h0, s.err, 2'h0, s.tx_st != TX_IDLE,
               s.seq != SEQ_IDLE, s.seq == SEQ_BODY && !s.buf_v && !s.end_req,
               s.armed, s.line_cnt, s.count};
            `SCI_OFS_RX_DATA: next_s.hrdata = {23'h000000, pop, pop ? fifo_mem[s.rptr] : 8'h00};
            `SCI_OFS_TERM: next_s.hrdata = {24'h000000, s.term};
            `SCI_OFS_END_STATUS: next_s.hrdata = {24'h000000, s.endst};
            `SCI_OFS_PARAM: next_s.hrdata = {16'h0000, s.param};
            `SCI_OFS_REQUEST: next_s.hrdata = {24'h000000, s.request};
            `SCI_OFS_FORMAT: next_s.hrdata = {18'h00000, s.sync2[17:4]};
            default: next_s.hrdata = 32'h00000000;
         endcase
      end

      // Reply sequencer: error prefix, body, then the fixed line end.
      case (s.seq)
         SEQ_ERR: begin
            ld = 1'b1;
            ld_char = prefix_char(s.idx, s.code);
         end
         SEQ_BODY: begin
            ld = s.buf_v;
            ld_char = s.buf_d;
            if (s.end_req && !s.buf_v) begin
               next_s.seq = SEQ_CR;
            end
         end
         SEQ_CR: begin
            ld = 1'b1;
            ld_char = `SCI_CHAR_CR;
         end
         SEQ_LF: begin
            ld = 1'b1;
            ld_char = `SCI_CHAR_LF;
         end
         SEQ_WAIT: begin
            if (s.tx_st == TX_IDLE) begin
               err_clr = s.snap;
               next_s.seq = SEQ_IDLE;
            end
         end
         default: ld = 1'b0;
      endcase
      next_s.rts = s.seq != SEQ_IDLE;

      // Transmitter; a new character starts only with the handshake lines up.
      if (ld && flow_ok && s.tx_st == TX_IDLE) begin
         next_s.tx_sh = ld_char & mask;
         next_s.tx_par = fmt.par_even ? ^(ld_char & mask) : ~^(ld_char & mask);
         next_s.tx_bits = fmt.nbits;
         next_s.tx_cnt = 5'h00;
         next_s.txd = 1'b0;
         next_s.tx_st = TX_START;
         case (s.seq)
            SEQ_ERR: begin
               next_s.idx = s.idx + 3'h1;
               if (s.idx == `SCI_PREFIX_LAST) begin
                  next_s.seq = SEQ_BODY;
               end
            end
            SEQ_BODY: next_s.buf_v = 1'b0;
            SEQ_CR: next_s.seq = SEQ_LF;
            default: next_s.seq = SEQ_WAIT;
         endcase
      end else if (s.tick && s.tx_st != TX_IDLE) begin
         next_s.tx_cnt = s.tx_cnt + 5'h01;
         case (s.tx_st)
            TX_START, TX_DATA: begin
               if (s.tx_cnt == `SCI_BIT_LAST) begin
                  next_s.tx_cnt = 5'h00;
                  if (s.tx_bits != 4'h0) begin
                     next_s.txd = s.tx_sh[0];
                     next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
                     next_s.tx_bits = s.tx_bits - 4'h1;
                     next_s.tx_st = TX_DATA;
                  end else if (fmt.par_en) begin
                     next_s.txd = s.tx_par;
                     next_s.tx_st = TX_PAR;
                  end else begin
                     next_s.txd = 1'b1;
                     next_s.tx_st = TX_STOP;
                  end
               end
            end
            TX_PAR: begin
               if (s.tx_cnt == `SCI_BIT_LAST) begin
                  next_s.tx_cnt = 5'h00;
                  next_s.txd = 1'b1;
                  next_s.tx_st = TX_STOP;
               end
            end
            TX_STOP: begin
               if (s.tx_cnt == (fmt.two_stop ? `SCI_STOP2_LAST : `SCI_BIT_LAST)) begin
                  next_s.tx_st = TX_IDLE;
               end
            end
            default: next_s.tx_st = TX_IDLE;
         endcase
      end

      // Errors are sticky; a new event wins over the clear in the same cycle.
      next_s.err = (s.err & ~err_clr) | err_set;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************

   // State record; line idles at mark and the port owns no reply after reset.
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= '0;
         s.sync1 <= 34'h3FFFFFFFF;
         s.sync2 <= 34'h3FFFFFFFF;
         s.rx_st <= RX_IDLE;
         s.tx_st <= TX_IDLE;
         s.seq <= SEQ_IDLE;
         s.txd <= 1'b1;
         s.remote <= `SCI_RST_REMOTE;
      end else begin
         s <= next_s;
      end
   end

   // Character storage; no reset, the pointers say what is valid.
   always_ff @(posedge mclk_in) begin
      if (push_ok) begin
         fifo_mem[s.wptr] <= s.hold_d;
      end
   end

   // Outputs come straight from the state record, except hresp_out, which is tied low.
   assign hrdata_out = s.hrdata;
   assign hreadyout_out = s.rdy;
   assign hresp_out = 1'b0;
   assign txd_out = s.txd;
   assign rts_out = s.rts;
   assign dtr_out = s.dtr;

endmodule : sci_top

// ### hdl/sci_cfg.svh
// Offsets, field positions, reset values and timing counts of the serial command interface.
`ifndef SCI_CFG_SVH
`define SCI_CFG_SVH

// ****************************************************************
// Clock and bit timing
// ****************************************************************
`define SCI_CLK_HZ 10000000
`define SCI_OVERSAMPLE 16
`define SCI_BAUD_P1 75
`define SCI_BAUD_P2 110
`define SCI_BAUD_P3 135
`define SCI_BAUD_P4 150
`define SCI_BAUD_P5 200
`define SCI_BAUD_P6 300
`define SCI_BAUD_P7 600
`define SCI_BAUD_P8 1200
`define SCI_BAUD_DEFAULT `SCI_BAUD_P6
`define SCI_SAMPLE_MID 5'h07
`define SCI_BIT_LAST 5'h0F
`define SCI_STOP2_LAST 5'h1F

// ****************************************************************
// Buffer and characters
// ****************************************************************
`define SCI_FIFO_DEPTH 9'h100
`define SCI_CHAR_CR 8'h0D
`define SCI_CHAR_LF 8'h0A
`define SCI_CHAR_E 8'h45
`define SCI_CHAR_R 8'h72
`define SCI_CHAR_ONE 8'h31
`define SCI_CHAR_ZERO 8'h30
`define SCI_CHAR_SPACE 8'h20
`define SCI_PREFIX_LAST 3'h5

// ****************************************************************
// Register map, byte offsets within the slave window
// ****************************************************************
`define SCI_OFS_CTRL 8'h00
`define SCI_OFS_STATUS 8'h04
`define SCI_OFS_RX_DATA 8'h08
`define SCI_OFS_TX_DATA 8'h0C
`define SCI_OFS_TERM 8'h10
`define SCI_OFS_END_STATUS 8'h14
`define SCI_OFS_PARAM 8'h18
`define SCI_OFS_REQUEST 8'h1C
`define SCI_OFS_FORMAT 8'h20
`define SCI_CTRL_REMOTE 0
`define SCI_CTRL_REPLY_START 1
`define SCI_CTRL_REPLY_END 2
`define SCI_ERR_PARITY 0
`define SCI_ERR_OVERRUN 1
`define SCI_ERR_FRAMING 2
`define SCI_ERR_OVERFLOW 3
`define SCI_RST_REMOTE 1'b0

`endif

// ### hdl/sci_pkg.sv
// Types shared by the serial command interface.
package sci_pkg;

   typedef enum logic [4:0] {
      RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
   } sci_rx_t;

   typedef enum logic [4:0] {
      TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
   } sci_tx_t;

   typedef enum logic [5:0] {
      SEQ_IDLE = 6'h01, SEQ_ERR = 6'h02, SEQ_BODY = 6'h04, SEQ_CR = 6'h08, SEQ_LF = 6'h10,
      SEQ_WAIT = 6'h20
   } sci_seq_t;

   typedef struct packed {
      logic [3:0] nbits;
      logic par_en;
      logic par_even;
      logic two_stop;
   } sci_fmt_t;

   typedef struct packed {
      logic [33:0] sync1;
      logic [33:0] sync2;
      logic [15:0] div_cnt;
      logic tick;
      sci_rx_t rx_st;
      logic [4:0] rx_cnt;
      logic [3:0] rx_bits;
      logic [7:0] rx_sh;
      logic rx_par;
      logic rx_perr;
      logic hold_v;
      logic [7:0] hold_d;
      logic [7:0] wptr;
      logic [7:0] rptr;
      logic [8:0] count;
      logic [8:0] line_cnt;
      logic armed;
      logic [3:0] err;
      logic [3:0] snap;
      logic [1:0] code;
      sci_seq_t seq;
      logic [2:0] idx;
      logic end_req;
      logic buf_v;
      logic [7:0] buf_d;
      sci_tx_t tx_st;
      logic [4:0] tx_cnt;
      logic [3:0] tx_bits;
      logic [7:0] tx_sh;
      logic tx_par;
      logic txd;
      logic rts;
      logic dtr;
      logic remote;
      logic [7:0] term;
      logic [7:0] endst;
      logic [15:0] param;
      logic [7:0] request;
      logic a_valid;
      logic a_write;
      logic [7:0] a_addr;
      logic [31:0] hrdata;
      logic rdy;
   } sci_state_t;

endpackage : sci_pkg

// ### tb/sci_monitor.sv
// Bound checker watching the ports of the serial command port.
`timescale 1ns/100ps
`include "sci_cfg.svh"
module sci_monitor (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_out,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic txd_out,
   input wire logic rts_out,
   input wire logic dtr_out
);
   // A read taken at this edge; its data must stand from the next edge.
   wire logic rd_take = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   a_resp_okay: assert property (hresp_out == 1'b0) else $error("bus response not okay");
   a_ready_up: assert property (!$past(rst_in) |-> hreadyout_out) else $error("slave not ready");
   a_dtr_up: assert property (!$past(rst_in) |-> dtr_out) else $error("dtr low");
   a_idle_mark:
      assert property (!rts_out && !$past(rts_out) |-> txd_out) else $error("line not idle");
   a_start_hold:
      assert property ($fell(txd_out) |-> !txd_out [*8]) else $error("start bit too short");
   a_count_cap:
      assert property (rd_take && haddr_in[7:0] == `SCI_OFS_STATUS |=> hrdata_out[8:0] <= 9'h100)
      else $error("fifo count above depth");
   a_lines_cap:
      assert property (rd_take && haddr_in[7:0] == `SCI_OFS_STATUS
         |=> hrdata_out[17:9] <= hrdata_out[8:0]) else $error("more lines than characters");
   a_hole_zero: assert property (rd_take && haddr_in[7:0] > `SCI_OFS_FORMAT
      |=> hrdata_out == 32'h0) else $error("unmapped read not zero");
   c_reply: cover property ($rose(rts_out));
   c_start: cover property ($fell(txd_out));
   c_status: cover property (rd_take && haddr_in[7:0] == `SCI_OFS_STATUS);
endmodule : sci_monitor

bind sci_top sci_monitor sci_monitor_i (.mclk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in,
   .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .txd_out, .rts_out, .dtr_out);

// ### tb/sci_host.sv
// Host serial port model that frames characters towards the device.
`timescale 1ns/100ps
module sci_host #(parameter int BIT_CLKS = 8320) (
   input wire logic mclk_in,
   output logic rxd_out,
   output logic cts_out,
   output logic dsr_out,
   output logic dcd_out
);
   // Handshakes stay on so the device may always answer; the line idles at mark.
   initial begin
      rxd_out = 1'b1;
      cts_out = 1'b1;
      dsr_out = 1'b1;
      dcd_out = 1'b1;
   end
   // The host speaks first and keeps lines short, so one character is a whole line.
   // The parity sense is an argument so that a mismatch can be provoked on purpose.
   task automatic send_char(input logic [6:0] ch, input logic odd);
      logic [9:0] frame;
      frame = {1'b1, (^ch) ^ odd, ch, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge mclk_in);
         rxd_out <= frame[i];
         repeat (BIT_CLKS - 1) @(posedge mclk_in);
      end
   endtask : send_char
endmodule : sci_host

// ### tb/tb_top.sv
// Self-checking bench for the serial command port.
`timescale 1ns/100ps
`include "sci_cfg.svh"
module tb_top;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic hsel_in = 1'b0;
   logic hwrite_in = 1'b0;
   logic [1:0] htrans_in = 2'h0;
   logic [31:0] haddr_in = 32'h0;
   logic [31:0] hwdata_in = 32'h0;
   logic [31:0] hrdata_out;
   logic [31:0] rd;
   logic hreadyout_out, txd_out, rts_out, dtr_out, rxd, cts, dsr, dcd;
   logic [7:0] e_char = `SCI_CHAR_E;
   int bad_count = 0;
   int num_checks = 0;
   always #50 mclk_in = ~mclk_in;
   // 1200 baud, one stop bit, even parity enabled, seven data bits.
   sci_top sci_top_i (.mclk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
      .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out,
      .hresp_out(), .rxd_in(rxd), .cts_in(cts), .dsr_in(dsr), .dcd_in(dcd), .txd_out,
      .rts_out, .dtr_out, .baud_select_switch_in(8'h80), .word_format_switch_in(6'h1E),
      .panel_param_in(16'h1234));
   sci_host sci_host_i (.mclk_in, .rxd_out(rxd), .cts_out(cts), .dsr_out(dsr), .dcd_out(dcd));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // A slave that never answers would hang the bus, so the wait is bounded.
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
      end while (hreadyout_out !== 1'b1 && n < 100);
      if (n >= 100) begin
         bad_count++;
         complete_run();
      end
   endtask : wait_ready
   // One single word: address phase until ready, then data phase until ready.
   task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
      hsel_in <= 1'b1;
      haddr_in <= {24'h0, adr};
      htrans_in <= 2'h2;
      hwrite_in <= wr;
      wait_ready();
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      wait_ready();
      rd = hrdata_out;
   endtask : bus
   task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
      bus(1'b0, adr, 32'h0);
      check(what, rd, exp);
   endtask : rdchk
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      int n;
      repeat (10) @(posedge mclk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      check("dtr", {31'h0, dtr_out}, 32'h1);
      rdchk(`SCI_OFS_CTRL, 32'h0, "ctrl");
      // The data buffer only reads free while a reply body is open.
      rdchk(`SCI_OFS_STATUS, 32'h00000000, "idle status");
      rdchk(`SCI_OFS_FORMAT, 32'h00001E80, "format");
      bus(1'b1, `SCI_OFS_TERM, 32'h5A);
      rdchk(`SCI_OFS_TERM, 32'h5A, "term");
      bus(1'b1, `SCI_OFS_END_STATUS, 32'hA5);
      rdchk(`SCI_OFS_END_STATUS, 32'hA5, "end status");
      bus(1'b1, `SCI_OFS_PARAM, 32'hBEEF);
      rdchk(`SCI_OFS_PARAM, 32'h1234, "param");
      rdchk(8'h40, 32'h0, "unmapped");
      // Odd parity against an even-parity device: the character is kept, flagged.
      sci_host_i.send_char(7'h0A, 1'b1);
      rdchk(`SCI_OFS_STATUS, 32'h01040201, "rx status");
      rdchk(`SCI_OFS_RX_DATA, 32'h0000010A, "popped char");
      bus(1'b1, `SCI_OFS_CTRL, 32'h2);
      for (n = 0; n < 500 && txd_out !== 1'b0; n++) @(posedge mclk_in);
      // A reply that never starts is a mismatch and ends the run.
      if (n >= 500) begin
         bad_count++;
         complete_run();
      end
      check("reply start", {31'h0, txd_out}, 32'h0);
      check("rts", {31'h0, rts_out}, 32'h1);
      repeat (12480) @(posedge mclk_in);
      check("code first bit", {31'h0, txd_out}, {31'h0, e_char[0]});
      complete_run();
   end
endmodule : tb_top
